//--- verilog/circ_defs.vh
// Constants for the CAN interrupt, mode handshake and bus-off recovery block.
// Assumes a 200 MHz bus clock and an 8-bit AXI4-Lite byte address.
`ifndef CIRC_DEFS_VH
`define CIRC_DEFS_VH

`define CIRC_CTRL0_OFS 8'h00
`define CIRC_CTRL1_OFS 8'h04
`define CIRC_RFLG_OFS 8'h08
`define CIRC_RIER_OFS 8'h0C
`define CIRC_TFLG_OFS 8'h10
`define CIRC_TIER_OFS 8'h14
`define CIRC_MISC_OFS 8'h18

`define CIRC_C0_INIT_REQUEST 0
`define CIRC_C0_SLEEP_REQUEST 1
`define CIRC_C0_BUS_WAKEUP_ENABLE 2
`define CIRC_C0_SLEEP_ACKNOWLEDGE 4
`define CIRC_C0_INIT_ACKNOWLEDGE 5
`define CIRC_C1_ENABLE 0
`define CIRC_C1_BUSOFF_RECOVERY_MODE 1
`define CIRC_RF_RXF 0
`define CIRC_RF_OVR 1
`define CIRC_RF_TRANSMIT_STATE_FIELD 2
`define CIRC_RF_RECEIVE_STATE_FIELD 4
`define CIRC_RF_CSC 6
`define CIRC_RF_WUP 7
`define CIRC_MISC_HOLD 0

`define CIRC_TXE_RST 3'h7
`define CIRC_WARN_LIMIT 8'h60
`define CIRC_PASSIVE_LIMIT 8'h80
`define CIRC_RECESSIVE_RUN 4'hB
`define CIRC_RECOVERY_RUNS 8'h80
`define CIRC_INIT_SYNC 3'h5
`define CIRC_RESP_OKAY 2'h0
`define CIRC_RESP_SLVERR 2'h2

`endif

//--- verilog/circ_sync2.v
// Two-stage synchroniser for one asynchronous level.
// Assumes the input has no timing relation to clk.
`timescale 1ns/10ps
module circ_sync2 #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk,
    input wire rst_n,
    input wire async_in,
    output wire sync_out
);
    reg meta_reg;
    reg sync_reg;

    always @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // circ_sync2

//--- verilog/circ_busoff_recovery.v
// Bus-off recovery counter: runs of recessive bits, then a recovery pulse.
// Assumes bit_tick is a one-cycle pulse per sampled bit on the same clock.
`timescale 1ns/10ps
`include "circ_defs.vh"
module circ_busoff_recovery #(
    parameter [3:0] RUN_LEN = `CIRC_RECESSIVE_RUN,
    parameter [7:0] RUNS = `CIRC_RECOVERY_RUNS
) (
    input wire clk,
    input wire rst_n,
    input wire bus_off,
    input wire run_en,
    input wire bit_tick,
    input wire recessive,
    input wire user_mode,
    input wire hold,
    output wire recover
);
    reg [3:0] run_cnt_reg;
    reg [7:0] runs_cnt_reg;
    reg done_reg;
    reg fired_reg;
    reg recover_reg;

    always @(posedge clk) begin
        if (!rst_n || !bus_off) begin
            run_cnt_reg <= 4'h0;
            runs_cnt_reg <= 8'h00;
            done_reg <= 1'b0;
            fired_reg <= 1'b0;
            recover_reg <= 1'b0;
        end else begin
            // Counting halts in sleep: run_en is low while sleep is acknowledged
            if (run_en && bit_tick && !done_reg) begin
                if (!recessive) begin
                    run_cnt_reg <= 4'h0;
                end else if (run_cnt_reg == RUN_LEN - 4'h1) begin
                    run_cnt_reg <= 4'h0;
                    runs_cnt_reg <= runs_cnt_reg + 8'h01;
                    if (runs_cnt_reg == RUNS - 8'h01)
                        done_reg <= 1'b1;
                end else begin
                    run_cnt_reg <= run_cnt_reg + 4'h1;
                end
            end
            recover_reg <= 1'b0;
            if (done_reg && !fired_reg && (!user_mode || !hold)) begin
                recover_reg <= 1'b1;
                fired_reg <= 1'b1;
            end
        end
    end

    assign recover = recover_reg;
endmodule // circ_busoff_recovery

//--- verilog/circ_top.v
// Interrupt flags, mode handshakes and bus-off recovery of a CAN controller.
// Assumes the frame engine runs on clk; only can_rx_pin is asynchronous.
`timescale 1ns/10ps
`include "circ_defs.vh"
module circ_top (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire bit_tick,
    input wire tx_active,
    input wire rx_active,
    input wire rx_msg_moved,
    input wire rx_overrun,
    input wire [2:0] tx_done,
    input wire [7:0] tx_err_cnt,
    input wire [7:0] rx_err_cnt,
    input wire bus_off,
    input wire engine_tx_bit,
    input wire can_rx_pin,
    output wire transmit_pin,
    output wire [2:0] tx_scheduled,
    output wire init_mode,
    output wire sleep_mode,
    output wire module_enable,
    output wire busoff_recover,
    output wire rx_shift_allow,
    output wire irq_wakeup,
    output wire irq_error,
    output wire irq_receive,
    output wire irq_transmit
);
    // Bus slave state
    reg aw_held_reg;
    reg [7:0] aw_addr_reg;
    reg w_held_reg;
    reg [7:0] w_data_reg;
    reg w_lane0_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;
    // Control and status
    reg init_request_reg;
    reg init_acknowledge_reg;
    reg [2:0] init_cnt_reg;
    reg sleep_request_reg;
    reg sleep_acknowledge_reg;
    reg bus_wakeup_enable_reg;
    reg module_enable_reg;
    reg busoff_recovery_mode_reg;
    reg busoff_hold_reg;
    reg bus_off_q_reg;
    reg wakeup_flag_reg;
    reg status_change_flag_reg;
    reg overrun_flag_reg;
    reg receive_full_flag_reg;
    reg [1:0] transmit_state_field_reg;
    reg [1:0] receive_state_field_reg;
    reg wakeup_irq_enable_reg;
    reg status_change_irq_enable_reg;
    reg overrun_irq_enable_reg;
    reg receive_full_irq_enable_reg;
    reg [2:0] tx_buffer_empty_flag_reg;
    reg [2:0] tx_buffer_empty_irq_enable_reg;
    reg transmit_pin_reg;
    reg rx_prev_reg;
    reg [31:0] rd_next;

    wire rx_sync;
    wire wr_go;
    wire [7:0] wd;
    wire wake_event;
    wire engine_idle;
    wire [1:0] transmit_state_field_next;
    wire [1:0] receive_state_field_next;

    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a == `CIRC_CTRL0_OFS) || (a == `CIRC_CTRL1_OFS) || (a == `CIRC_RFLG_OFS) ||
                (a == `CIRC_RIER_OFS) || (a == `CIRC_TFLG_OFS) || (a == `CIRC_TIER_OFS) ||
                (a == `CIRC_MISC_OFS);
        end
    endfunction

    // Bus state from an error counter: ok, warning, passive, bus-off
    function [1:0] err_state;
        input [7:0] cnt;
        input off;
        begin
            if (off)
                err_state = 2'h3;
            else if (cnt >= `CIRC_PASSIVE_LIMIT)
                err_state = 2'h2;
            else if (cnt >= `CIRC_WARN_LIMIT)
                err_state = 2'h1;
            else
                err_state = 2'h0;
        end
    endfunction

    function wsel;
        input [7:0] a;
        input [7:0] ofs;
        begin
            wsel = a == ofs;
        end
    endfunction

    circ_sync2 #(
        .RESET_VAL(1'b1)
    ) u_rx_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(can_rx_pin),
        .sync_out(rx_sync)
    );

    circ_busoff_recovery u_recovery (
        .clk(clk),
        .rst_n(rst_n),
        .bus_off(bus_off),
        .run_en(module_enable_reg & ~sleep_acknowledge_reg),
        .bit_tick(bit_tick),
        .recessive(rx_sync),
        .user_mode(busoff_recovery_mode_reg),
        .hold(busoff_hold_reg),
        .recover(busoff_recover)
    );

    // AXI4-Lite slave: one write and one read under way at a time
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    // All writable bits live in byte lane 0
    assign wr_go = aw_held_reg & w_held_reg & w_lane0_reg;
    assign wd = w_data_reg;

    always @(posedge clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `CIRC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `CIRC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (aw_held_reg && w_held_reg) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= addr_ok(aw_addr_reg) ? `CIRC_RESP_OKAY : `CIRC_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_next;
                rresp_reg <= addr_ok(s_axi_araddr) ? `CIRC_RESP_OKAY : `CIRC_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    always @* begin
        rd_next = 32'h00000000;
        case (s_axi_araddr)
            `CIRC_CTRL0_OFS: begin
                rd_next[`CIRC_C0_INIT_REQUEST] = init_request_reg;
                rd_next[`CIRC_C0_SLEEP_REQUEST] = sleep_request_reg;
                rd_next[`CIRC_C0_BUS_WAKEUP_ENABLE] = bus_wakeup_enable_reg;
                rd_next[`CIRC_C0_SLEEP_ACKNOWLEDGE] = sleep_acknowledge_reg;
                rd_next[`CIRC_C0_INIT_ACKNOWLEDGE] = init_acknowledge_reg;
            end
            `CIRC_CTRL1_OFS: begin
                rd_next[`CIRC_C1_ENABLE] = module_enable_reg;
                rd_next[`CIRC_C1_BUSOFF_RECOVERY_MODE] = busoff_recovery_mode_reg;
            end
            `CIRC_RFLG_OFS: begin
                rd_next[`CIRC_RF_RXF] = receive_full_flag_reg;
                rd_next[`CIRC_RF_OVR] = overrun_flag_reg;
                rd_next[`CIRC_RF_TRANSMIT_STATE_FIELD+1:`CIRC_RF_TRANSMIT_STATE_FIELD] = transmit_state_field_reg;
                rd_next[`CIRC_RF_RECEIVE_STATE_FIELD+1:`CIRC_RF_RECEIVE_STATE_FIELD] = receive_state_field_reg;
                rd_next[`CIRC_RF_CSC] = status_change_flag_reg;
                rd_next[`CIRC_RF_WUP] = wakeup_flag_reg;
            end
            `CIRC_RIER_OFS: begin
                rd_next[`CIRC_RF_RXF] = receive_full_irq_enable_reg;
                rd_next[`CIRC_RF_OVR] = overrun_irq_enable_reg;
                rd_next[`CIRC_RF_CSC] = status_change_irq_enable_reg;
                rd_next[`CIRC_RF_WUP] = wakeup_irq_enable_reg;
            end
            `CIRC_TFLG_OFS: rd_next[2:0] = tx_buffer_empty_flag_reg;
            `CIRC_TIER_OFS: rd_next[2:0] = tx_buffer_empty_irq_enable_reg;
            `CIRC_MISC_OFS: rd_next[`CIRC_MISC_HOLD] = busoff_hold_reg;
            default: rd_next = 32'h00000000;
        endcase
    end

    // Bus activity only counts with wake-up enabled; otherwise only a write clearing sleep request ends sleep
    assign wake_event = sleep_acknowledge_reg & bus_wakeup_enable_reg & rx_prev_reg & ~rx_sync;
    assign engine_idle = ~tx_active & ~rx_active;
    assign transmit_state_field_next = err_state(tx_err_cnt, bus_off);
    assign receive_state_field_next = err_state(rx_err_cnt, bus_off);

    // Mode handshakes
    always @(posedge clk) begin
        if (!rst_n) begin
            init_request_reg <= 1'b1;
            init_acknowledge_reg <= 1'b0;
            init_cnt_reg <= 3'h0;
            sleep_request_reg <= 1'b0;
            sleep_acknowledge_reg <= 1'b0;
            bus_wakeup_enable_reg <= 1'b0;
            module_enable_reg <= 1'b0;
            busoff_recovery_mode_reg <= 1'b0;
            rx_prev_reg <= 1'b1;
            transmit_pin_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_sync;
            if (wr_go && wsel(aw_addr_reg, `CIRC_CTRL1_OFS)) begin
                module_enable_reg <= wd[`CIRC_C1_ENABLE];
                if (init_acknowledge_reg)
                    busoff_recovery_mode_reg <= wd[`CIRC_C1_BUSOFF_RECOVERY_MODE];
            end
            if (wr_go && wsel(aw_addr_reg, `CIRC_CTRL0_OFS)) begin
                bus_wakeup_enable_reg <= wd[`CIRC_C0_BUS_WAKEUP_ENABLE];
                if (wd[`CIRC_C0_INIT_REQUEST])
                    init_request_reg <= 1'b1;
                else if (init_acknowledge_reg)
                    init_request_reg <= 1'b0;
            end
            // Request passes the synchronising stages before the ack shows
            if (!init_request_reg) begin
                init_cnt_reg <= 3'h0;
                init_acknowledge_reg <= 1'b0;
            end else if (init_cnt_reg != `CIRC_INIT_SYNC) begin
                init_cnt_reg <= init_cnt_reg + 3'h1;
            end else if (engine_idle) begin
                init_acknowledge_reg <= 1'b1;
            end
            if (wake_event) begin
                sleep_request_reg <= 1'b0;
                sleep_acknowledge_reg <= 1'b0;
            end else begin
                if (wr_go && wsel(aw_addr_reg, `CIRC_CTRL0_OFS)) begin
                    if (wd[`CIRC_C0_SLEEP_REQUEST])
                        sleep_request_reg <= 1'b1;
                    else if (sleep_acknowledge_reg)
                        sleep_request_reg <= 1'b0;
                end
                if (!sleep_request_reg)
                    sleep_acknowledge_reg <= 1'b0;
                else if (engine_idle && (&tx_buffer_empty_flag_reg))
                    sleep_acknowledge_reg <= 1'b1;
            end
            // Pin is forced recessive whenever the engine is stopped
            transmit_pin_reg <= (init_request_reg | sleep_acknowledge_reg | ~module_enable_reg) ? 1'b1 :
                engine_tx_bit;
        end
    end

    // Flags: set wins over a write-one clear in the same cycle
    always @(posedge clk) begin
        if (!rst_n || init_acknowledge_reg) begin
            wakeup_flag_reg <= 1'b0;
            status_change_flag_reg <= 1'b0;
            overrun_flag_reg <= 1'b0;
            receive_full_flag_reg <= 1'b0;
            transmit_state_field_reg <= 2'h0;
            receive_state_field_reg <= 2'h0;
            wakeup_irq_enable_reg <= 1'b0;
            status_change_irq_enable_reg <= 1'b0;
            overrun_irq_enable_reg <= 1'b0;
            receive_full_irq_enable_reg <= 1'b0;
            tx_buffer_empty_flag_reg <= `CIRC_TXE_RST;
            tx_buffer_empty_irq_enable_reg <= 3'h0;
        end else begin
            if (wr_go && wsel(aw_addr_reg, `CIRC_RFLG_OFS)) begin
                if (wd[`CIRC_RF_WUP])
                    wakeup_flag_reg <= 1'b0;
                if (wd[`CIRC_RF_CSC])
                    status_change_flag_reg <= 1'b0;
                if (wd[`CIRC_RF_OVR])
                    overrun_flag_reg <= 1'b0;
                if (wd[`CIRC_RF_RXF])
                    receive_full_flag_reg <= 1'b0;
            end
            if (wr_go && wsel(aw_addr_reg, `CIRC_RIER_OFS)) begin
                wakeup_irq_enable_reg <= wd[`CIRC_RF_WUP];
                status_change_irq_enable_reg <= wd[`CIRC_RF_CSC];
                overrun_irq_enable_reg <= wd[`CIRC_RF_OVR];
                receive_full_irq_enable_reg <= wd[`CIRC_RF_RXF];
            end
            if (wr_go && wsel(aw_addr_reg, `CIRC_TIER_OFS))
                tx_buffer_empty_irq_enable_reg <= wd[2:0];
            // Clearing an empty flag hands that buffer to the transmitter
            if (wr_go && wsel(aw_addr_reg, `CIRC_TFLG_OFS))
                tx_buffer_empty_flag_reg <= (tx_buffer_empty_flag_reg & ~wd[2:0]) | tx_done;
            else
                tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_reg | tx_done;
            if (wake_event)
                wakeup_flag_reg <= 1'b1;
            if (rx_overrun)
                overrun_flag_reg <= 1'b1;
            if (rx_msg_moved && !sleep_acknowledge_reg)
                receive_full_flag_reg <= 1'b1;
            transmit_state_field_reg <= transmit_state_field_next;
            receive_state_field_reg <= receive_state_field_next;
            if (transmit_state_field_next != transmit_state_field_reg || receive_state_field_next != receive_state_field_reg)
                status_change_flag_reg <= 1'b1;
        end
    end

    // User hold arms on entry to bus-off; software clears it by writing one
    always @(posedge clk) begin
        if (!rst_n) begin
            busoff_hold_reg <= 1'b0;
            bus_off_q_reg <= 1'b0;
        end else begin
            bus_off_q_reg <= bus_off;
            if (bus_off && !bus_off_q_reg && busoff_recovery_mode_reg)
                busoff_hold_reg <= 1'b1;
            else if (wr_go && wsel(aw_addr_reg, `CIRC_MISC_OFS) && wd[`CIRC_MISC_HOLD])
                busoff_hold_reg <= 1'b0;
        end
    end

    // Next frame moves forward only after receive-full is cleared, not in sleep
    assign rx_shift_allow = ~sleep_acknowledge_reg & ~receive_full_flag_reg;
    assign tx_scheduled = ~tx_buffer_empty_flag_reg;
    assign init_mode = init_request_reg;
    assign sleep_mode = sleep_acknowledge_reg;
    assign module_enable = module_enable_reg;
    assign transmit_pin = transmit_pin_reg;
    // Levels held as long as an enabled flag is set
    assign irq_wakeup = wakeup_flag_reg & wakeup_irq_enable_reg;
    assign irq_error = (status_change_flag_reg & status_change_irq_enable_reg) |
        (overrun_flag_reg & overrun_irq_enable_reg);
    assign irq_receive = receive_full_flag_reg & receive_full_irq_enable_reg;
    assign irq_transmit = |(tx_buffer_empty_flag_reg & tx_buffer_empty_irq_enable_reg);
endmodule // circ_top

//--- testbench/circ_asserts.sv
// Checker for the interrupt and recovery block, bound to its top.
// Assumes one clock and the synchronous reset rst_n.
`timescale 1ns/10ps
module circ_checker (
    input wire clk,
    input wire rst_n,
    input wire s_axi_bvalid,
    input wire rx_msg_moved,
    input wire [2:0] tx_done,
    input wire bus_off,
    input wire bit_tick,
    input wire [2:0] tx_scheduled,
    input wire sleep_mode,
    input wire init_mode,
    input wire busoff_recover,
    input wire irq_wakeup,
    input wire irq_error,
    input wire irq_receive,
    input wire irq_transmit
);
    reg [10:0] tick_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Saturates, so a long bus-off cannot wrap to a false low count
    always @(posedge clk) begin
        if (!rst_n || !bus_off)
            tick_reg <= 11'h000;
        else if (bit_tick && tick_reg != 11'h7FF)
            tick_reg <= tick_reg + 11'h001;
    end
    property p_rx_cause; $rose(irq_receive) |-> $past(rx_msg_moved) || $rose(s_axi_bvalid); endproperty
    property p_tx_cause; $rose(irq_transmit) |-> $past(|tx_done) || $rose(s_axi_bvalid); endproperty
    // Init mode returns flags and enables to defaults, a legal drop
    property p_rx_fall; $fell(irq_receive) |-> $rose(s_axi_bvalid) || init_mode; endproperty
    property p_err_fall; $fell(irq_error) |-> $rose(s_axi_bvalid) || init_mode; endproperty
    property p_sched; tx_done[0] |=> !tx_scheduled[0]; endproperty
    property p_sleep; $rose(sleep_mode) |-> tx_scheduled == 3'h0; endproperty
    property p_recover; busoff_recover |-> tick_reg >= 11'h580; endproperty
    property p_wake; $rose(irq_wakeup) |-> $past(sleep_mode) || $rose(s_axi_bvalid); endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("receive request without cause");
    a_tx_cause: assert property (p_tx_cause) else $error("transmit request without cause");
    a_rx_fall: assert property (p_rx_fall) else $error("receive request dropped unasked");
    a_err_fall: assert property (p_err_fall) else $error("error request dropped unasked");
    a_sched: assert property (p_sched) else $error("done buffer still scheduled");
    a_sleep: assert property (p_sleep) else $error("sleep with buffers scheduled");
    a_recover: assert property (p_recover) else $error("recovery before enough bits");
    a_wake: assert property (p_wake) else $error("wake request outside sleep");
    c_rx: cover property ($rose(irq_receive));
    c_sleep: cover property ($rose(sleep_mode));
    c_recover: cover property (busoff_recover);
endmodule // circ_checker
bind circ_top circ_checker u_chk (.*);

//--- testbench/circ_can_node.sv
// Other nodes on the shared bus, plus the bit sample strobe.
// Assumes the bus is wired-AND and idles recessive (high).
`timescale 1ns/10ps
module circ_can_node (
    input wire clk,
    input wire rst_n,
    input wire transmit_pin,
    input wire wake,
    output reg bit_tick,
    output wire can_rx_pin
);
    // Any dominant node pulls the bus low
    assign can_rx_pin = transmit_pin & ~wake;
    // A bit every second clock keeps recovery runs short
    always @(posedge clk) begin
        if (!rst_n)
            bit_tick <= 1'b0;
        else
            bit_tick <= ~bit_tick;
    end
endmodule // circ_can_node

//--- testbench/circ_bench.sv
// Bench: register sequences over AXI4-Lite, engine pulses, bus wake-up.
// Assumes the design, the node model and the checker are compiled first.
`timescale 1ns/10ps
module can_interrupt_and_recovery_control_bench;
    reg clk = 1'b0, rst_n = 1'b0, wake = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_err_cnt = 8'h00, rx_err_cnt = 8'h00;
    reg [31:0] s_axi_wdata = 32'h00000000;
    reg [31:0] rd_data = 32'h00000000;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [2:0] tx_done = 3'h0;
    reg [1:0] resp;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0, tx_active = 1'b0, rx_active = 1'b0, engine_tx_bit = 1'b1;
    reg rx_msg_moved = 1'b0, rx_overrun = 1'b0, bus_off = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] tx_scheduled;
    wire bit_tick, can_rx_pin, transmit_pin, init_mode, sleep_mode, module_enable, busoff_recover;
    wire rx_shift_allow, irq_wakeup, irq_error, irq_receive, irq_transmit;
    integer failures = 0, n_checks = 0, cyc = 0, i;
    circ_top dut_u (.*);
    circ_can_node node_u (.*);
    initial forever #2.5 clk = ~clk;
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tk(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            @(posedge clk);
            while (!s_axi_bvalid) begin
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                @(posedge clk);
            end
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            // One edge between transfers, so no strobe is set twice in one step
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(posedge clk);
            while (!s_axi_arready) @(posedge clk);
            s_axi_arvalid <= 1'b0;
            @(posedge clk);
            while (!s_axi_rvalid) @(posedge clk);
            rd_data = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge clk);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            complete_run;
        end
    end
    initial begin
        tk(16);
        rst_n <= 1'b1;
        tk(1);
        wr(8'h00, 32'h00000000);
        for (i = 0; i < 20 && !rd_data[5]; i = i + 1) rd(8'h00);
        chk("ctrl0", rd_data, 32'h00000021);
        rd(8'h10);
        chk("tflg", rd_data, 32'h00000007);
        rd(8'h1C);
        chk("unmapped", {30'h0, resp}, 32'h00000002);
        wr(8'h1C, 32'h00000001);
        chk("bresp", {30'h0, resp}, 32'h00000002);
        wr(8'h04, 32'h00000001);
        chk("bresp_ok", {30'h0, resp}, 32'h00000000);
        wr(8'h00, 32'h00000000);
        chk("enable", {init_mode, module_enable}, 32'h00000001);
        rd(8'h04);
        chk("ctrl1", rd_data, 32'h00000001);
        wr(8'h0C, 32'h000000C3);
        wr(8'h14, 32'h00000001);
        chk("irq_tx", irq_transmit, 32'h1);
        wr(8'h10, 32'h00000006);
        chk("irq_tx", irq_transmit, 32'h1);
        wr(8'h14, 32'h00000006);
        chk("irq_tx", irq_transmit, 32'h0);
        wr(8'h10, 32'h00000001);
        chk("sched", tx_scheduled, 32'h7);
        tx_done <= 3'h2;
        tk(1);
        tx_done <= 3'h0;
        tk(1);
        chk("irq_tx", irq_transmit, 32'h1);
        rx_overrun <= 1'b1;
        tk(1);
        rx_overrun <= 1'b0;
        tk(1);
        chk("irq_err", irq_error, 32'h1);
        wr(8'h08, 32'h00000001);
        chk("irq_err", irq_error, 32'h1);
        wr(8'h08, 32'h00000002);
        chk("irq_err", irq_error, 32'h0);
        for (i = 0; i < 2; i = i + 1) begin
            rx_msg_moved <= 1'b1;
            tk(1);
            rx_msg_moved <= 1'b0;
            tk(1);
            chk("irq_rx", irq_receive, 32'h1);
            wr(8'h08, 32'h00000001);
            chk("irq_rx", irq_receive, 32'h0);
        end
        tx_err_cnt <= 8'h60;
        rx_err_cnt <= 8'h80;
        tk(4);
        rd(8'h08);
        chk("rflg", rd_data, 32'h00000064);
        wr(8'h08, 32'h00000040);
        rd(8'h08);
        chk("rflg", rd_data, 32'h00000024);
        tx_done <= 3'h7;
        tk(1);
        tx_done <= 3'h0;
        wr(8'h00, 32'h00000006);
        for (i = 0; i < 20 && !sleep_mode; i = i + 1) tk(1);
        rd(8'h00);
        chk("ctrl0", rd_data, 32'h00000016);
        rx_msg_moved <= 1'b1;
        tk(1);
        rx_msg_moved <= 1'b0;
        tk(1);
        chk("irq_rx", irq_receive, 32'h0);
        chk("shift", rx_shift_allow, 32'h0);
        wake <= 1'b1;
        for (i = 0; i < 20 && sleep_mode; i = i + 1) tk(1);
        wake <= 1'b0;
        chk("irq_wake", irq_wakeup, 32'h1);
        wr(8'h08, 32'h00000080);
        chk("irq_wake", irq_wakeup, 32'h0);
        bus_off <= 1'b1;
        for (i = 0; i < 4000 && !busoff_recover; i = i + 1) tk(1);
        bus_off <= 1'b0;
        chk("recover", {busoff_recover, i > 2800}, 32'h3);
        // User-request recovery: mode bit only writable in init mode
        wr(8'h00, 32'h00000001);
        for (i = 0; i < 20 && !rd_data[5]; i = i + 1) rd(8'h00);
        wr(8'h04, 32'h00000003);
        wr(8'h00, 32'h00000000);
        rd(8'h04);
        chk("ctrl1", rd_data, 32'h00000003);
        bus_off <= 1'b1;
        tk(2);
        rd(8'h18);
        chk("hold", rd_data, 32'h00000001);
        for (i = 0; i < 3100 && !busoff_recover; i = i + 1) tk(1);
        chk("held", busoff_recover, 32'h0);
        wr(8'h18, 32'h00000001);
        for (i = 0; i < 8 && !busoff_recover; i = i + 1) tk(1);
        chk("user_rec", busoff_recover, 32'h1);
        bus_off <= 1'b0;
        complete_run;
    end
endmodule // can_interrupt_and_recovery_control_bench
